/* File: src/rss_reset_status.v */
// Summary of operation
// - any active reset source asserts the master system reset
// - every reset kind sets its own cause flag in the status register
// - power-on clears the status register except brown-out and power-on flags, set
// - software may set or clear flags; writes never cause a reset
// - bit 15 set by trap conflict, cleared by power-on or software
// - bit 14 set by illegal opcode, address mode or uninitialised register
// - bit 9 set by configuration mismatch, cleared by power-on or software
// - bit 8 high keeps regulator and program memory on in low power
// - bit 7 set by master-clear pin reset
// - bit 6 set by the software reset instruction
// - bit 5 enables watchdog; unprogrammed fuse forces watchdog on
// - bit 4 set by watchdog time-out; cleared by clear or power-save
// - bit 3 set entering sleep, bit 2 set entering idle
// - bits 1 and 0 set by power-on; bit 1 also by brown-out
// - bits 13 to 10 read zero and ignore writes
// - only status and oscillator depend on reset type; two regs power-on only
// - oscillator control after reset depends on type and fuse selection
// - undefined registers keep contents across every reset, power-on included
// - master reset is released only after the state-reset interval
`timescale 1ns/10ps
`default_nettype none
`include "rss_consts.vh"
module rss_reset_status #(
   parameter TRST_CYC = (`RSS_TRST_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS,
   parameter TVREG_CYC = (`RSS_TVREG_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS,
   parameter OSC_W = 3
) (
   input wire clk, // 25 mhz system clock
   input wire rstn, // power-on reset, active low
   input wire brownout_in, // brown-out detect, high active, async
   input wire master_clear_pin_n, // external pin reset, low active, async
   input wire soft_reset_req, // reset instruction pulse
   input wire wdt_timeout, // watchdog time-out pulse
   input wire cfg_mismatch, // configuration mismatch pulse
   input wire trap_conflict, // trap conflict pulse
   input wire bad_opcode, // illegal opcode or address mode pulse
   input wire uninit_wreg_reset, // uninitialised working register pulse
   input wire watchdog_clear_instr, // watchdog clear instruction pulse
   input wire sleep_instr, // power-save operand zero pulse
   input wire idle_instr, // power-save operand one pulse
   input wire wake_req, // wake-up event from sleep or idle
   input wire fuse_watchdog_enable, // watchdog fuse, 1 = unprogrammed
   input wire [OSC_W-1:0] initial_oscillator_select, // fuse field
   input wire [OSC_W-1:0] osc_current, // running oscillator selection
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error, unmapped address
   output reg master_system_reset, // high while system is held in reset
   output reg watchdog_enabled, // watchdog runs
   output reg regulator_standby, // regulator in standby
   output reg program_mem_off, // program memory unpowered
   output reg core_halted, // core stopped in sleep, idle or wake delay
   output reg [OSC_W-1:0] oscillator_control_reg // oscillator selection at reset
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: three stages, change accepted when stages two and three agree
reg [2:0] bor_sync;
reg [2:0] pin_sync;
reg bor_lvl;
reg pin_lvl;
// a level only moves once the last two stages agree, so one glitch never counts
function settled;
   input [2:0] s;
   input cur;
   begin
      settled = (s[1] == s[2]) ? s[2] : cur;
   end
endfunction
// brown-out detector, idle low
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      bor_sync <= 3'h0;
      bor_lvl <= 1'b0;
   end else begin
      bor_sync <= {bor_sync[1:0], brownout_in};
      bor_lvl <= settled(bor_sync, bor_lvl);
   end
end
// master-clear pin, inverted so its idle level is low and no false reset follows power-on
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      pin_sync <= 3'h0;
      pin_lvl <= 1'b0;
   end else begin
      pin_sync <= {pin_sync[1:0], ~master_clear_pin_n};
      pin_lvl <= settled(pin_sync, pin_lvl);
   end
end

////////////////////////////////////////////////////////////////////////////////
// reset source combine; power-on is the async rstn itself
wire src_any;
wire bad_op;
assign bad_op = bad_opcode | uninit_wreg_reset;
assign src_any = bor_lvl | pin_lvl | soft_reset_req | wdt_timeout |
   cfg_mismatch | trap_conflict | bad_op;

////////////////////////////////////////////////////////////////////////////////
// apb decode; zero wait state, every access ends in its first access cycle
wire acc;
wire wr_any;
wire wr;
wire rd_ok;
assign acc = psel & penable;
assign wr_any = acc & pwrite;
assign wr = wr_any & (paddr == `RSS_ADDR_STATUS);
function is_mapped;
   input [11:0] a;
   begin
      is_mapped = (a == `RSS_ADDR_STATUS) || (a == `RSS_ADDR_OSC) ||
         (a == `RSS_ADDR_CAL) || (a == `RSS_ADDR_FLASH) || (a == `RSS_ADDR_CTRL);
   end
endfunction
assign rd_ok = is_mapped(paddr);

////////////////////////////////////////////////////////////////////////////////
// status register; hardware set wins over a software clear in the same cycle
reg [15:0] status;
reg [15:0] hw_set;
reg [15:0] hw_clr;
reg [15:0] next_status;
always @* begin
   hw_set = 16'h0000;
   hw_clr = 16'h0000;
   hw_set[`RSS_B_TRAP] = trap_conflict;
   hw_set[`RSS_B_OPC] = bad_op;
   hw_set[`RSS_B_CFG] = cfg_mismatch;
   hw_set[`RSS_B_PIN] = pin_lvl;
   hw_set[`RSS_B_SOFT] = soft_reset_req;
   hw_set[`RSS_B_WATCHDOG_TIMEOUT_FLAG] = wdt_timeout;
   hw_set[`RSS_B_SLEEP] = sleep_instr;
   hw_set[`RSS_B_IDLE] = idle_instr;
   hw_set[`RSS_B_BOR] = bor_lvl;
   hw_clr[`RSS_B_WATCHDOG_TIMEOUT_FLAG] = watchdog_clear_instr | sleep_instr | idle_instr;
   next_status = status;
   if (wr) next_status = pwdata[15:0];
   next_status = (next_status & ~hw_clr) | hw_set;
   next_status = next_status & `RSS_STATUS_MASK;
end
always @(posedge clk or negedge rstn) begin
   if (!rstn) status <= `RSS_STATUS_POR;
   else status <= next_status;
end

////////////////////////////////////////////////////////////////////////////////
// power-on-only registers: calibration and flash control survive other resets
reg [15:0] cal_reg;
reg [15:0] flash_reg;
reg [15:0] scratch; // no defined reset value: kept across every reset
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      cal_reg <= 16'h0000;
      flash_reg <= 16'h0000;
   end else if (wr_any && !wr) begin
      if (paddr == `RSS_ADDR_CAL) cal_reg <= pwdata[15:0];
      if (paddr == `RSS_ADDR_FLASH) flash_reg <= pwdata[15:0];
   end
end
// scratch is deliberately never reset, so it is unknown after power-on
always @(posedge clk) begin
   if (wr_any && paddr == `RSS_ADDR_CTRL) scratch <= pwdata[15:0];
end

////////////////////////////////////////////////////////////////////////////////
// sequencer: hold reset for the state-reset interval; sleep/idle and wake delay
localparam ST_RST = 4'h1;
localparam ST_RUN = 4'h2;
localparam ST_LOW = 4'h4;
localparam ST_WAKE = 4'h8;
reg [3:0] state;
reg [3:0] next_state;
reg [15:0] cnt;
reg [15:0] next_cnt;
reg was_por;
reg low_standby;
always @* begin
   next_state = state;
   next_cnt = cnt;
   case (state)
      ST_RST: begin
         if (src_any) next_cnt = 16'h0000; // a fresh cause restarts the interval
         else if (cnt >= TRST_CYC[15:0] - 16'h0001) next_state = ST_RUN;
         else next_cnt = cnt + 16'h0001;
      end
      ST_RUN: begin
         if (sleep_instr | idle_instr) next_state = ST_LOW;
      end
      ST_LOW: begin
         next_cnt = 16'h0000;
         if (wake_req) next_state = low_standby ? ST_WAKE : ST_RUN;
      end
      ST_WAKE: begin
         if (cnt >= TVREG_CYC[15:0] - 16'h0001) next_state = ST_RUN;
         else next_cnt = cnt + 16'h0001;
      end
      default: next_state = ST_RST;
   endcase
   if (src_any) begin
      next_state = ST_RST;
      next_cnt = 16'h0000;
   end
end
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      state <= ST_RST;
      cnt <= 16'h0000;
      was_por <= 1'b1;
      low_standby <= 1'b0;
   end else begin
      state <= next_state;
      cnt <= next_cnt;
      // a brown-out seen during this reset also asks for the fuse oscillator choice
      if (bor_lvl) was_por <= 1'b1;
      else if (next_state == ST_RUN) was_por <= 1'b0;
      // only a sleep entry with the regulator allowed to drop needs the wake delay
      if (state == ST_RUN && sleep_instr) low_standby <= ~status[`RSS_B_VREG];
      else if (state == ST_RUN && idle_instr) low_standby <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// regulator standby and memory power-down share one decode
function standby_decode;
   input [3:0] ns;
   input [15:0] st;
   begin
      standby_decode = (ns == ST_LOW) & ~st[`RSS_B_VREG];
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// system reset and watchdog enable, launched from next-state values
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      master_system_reset <= 1'b1;
      watchdog_enabled <= 1'b0;
   end else begin
      master_system_reset <= (next_state == ST_RST);
      watchdog_enabled <= fuse_watchdog_enable | next_status[`RSS_B_WDEN];
   end
end

// low-power outputs; memory and regulator always drop together
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      regulator_standby <= 1'b0;
      program_mem_off <= 1'b0;
      core_halted <= 1'b0;
   end else begin
      regulator_standby <= standby_decode(next_state, next_status);
      program_mem_off <= standby_decode(next_state, next_status);
      core_halted <= (next_state == ST_LOW) | (next_state == ST_WAKE);
   end
end

// oscillator selection, reloaded on every edge spent in reset
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      oscillator_control_reg <= {OSC_W{1'b0}};
   end else if (state == ST_RST) begin
      // power-on and brown-out take the fuse choice, other resets keep the running clock
      oscillator_control_reg <= (was_por | bor_lvl) ? initial_oscillator_select
         : osc_current;
   end
end

////////////////////////////////////////////////////////////////////////////////
// apb response; write to status never feeds src_any, so it cannot reset
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
   end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `RSS_ADDR_STATUS: prdata <= {16'h0000, status};
            `RSS_ADDR_OSC: prdata <= {{(32-OSC_W){1'b0}}, oscillator_control_reg};
            `RSS_ADDR_CAL: prdata <= {16'h0000, cal_reg};
            `RSS_ADDR_FLASH: prdata <= {16'h0000, flash_reg};
            `RSS_ADDR_CTRL: prdata <= {16'h0000, scratch};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
end

endmodule // rss_reset_status
`default_nettype wire

/* File: src/rss_consts.vh */
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH
// register byte addresses (apb, 32-bit words)
`define RSS_ADDR_STATUS 12'h000
`define RSS_ADDR_OSC 12'h004
`define RSS_ADDR_CAL 12'h008
`define RSS_ADDR_FLASH 12'h00C
`define RSS_ADDR_CTRL 12'h010
// status field positions
`define RSS_B_TRAP 15
`define RSS_B_OPC 14
`define RSS_B_CFG 9
`define RSS_B_VREG 8
`define RSS_B_PIN 7
`define RSS_B_SOFT 6
`define RSS_B_WDEN 5
`define RSS_B_WATCHDOG_TIMEOUT_FLAG 4
`define RSS_B_SLEEP 3
`define RSS_B_IDLE 2
`define RSS_B_BOR 1
`define RSS_B_POR 0
// implemented bits of the status word (13..10 unimplemented)
`define RSS_STATUS_MASK 16'hC3FF
`define RSS_STATUS_POR 16'h0003
// timing
`define RSS_TRST_NS 32000
`define RSS_TVREG_NS 10000
`define RSS_CLK_NS 40
`endif

/* File: tb/rss_reset_status_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rss_consts.vh"
module rss_reset_status_checker #(
   parameter int TRST_CYC = 800
) (
   input wire logic clk, // clock
   input wire logic rstn, // power-on
   input wire logic brownout_in, // pin
   input wire logic master_clear_pin_n, // pin
   input wire logic soft_reset_req, // source
   input wire logic wdt_timeout, // source
   input wire logic cfg_mismatch, // source
   input wire logic trap_conflict, // source
   input wire logic bad_opcode, // source
   input wire logic uninit_wreg_reset, // source
   input wire logic sleep_instr, // instr
   input wire logic wake_req, // wake
   input wire logic fuse_watchdog_enable, // fuse
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [11:0] paddr, // apb
   input wire logic [31:0] prdata, // apb
   input wire logic pready, // apb
   input wire logic master_system_reset, // out
   input wire logic watchdog_enabled, // out
   input wire logic regulator_standby, // out
   input wire logic program_mem_off, // out
   input wire logic core_halted // out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   // quiet edges since any source; pins counted raw, so the design may only lag
   wire sync_src = soft_reset_req | wdt_timeout | cfg_mismatch | trap_conflict | bad_opcode
      | uninit_wreg_reset;
   wire any_src = sync_src | brownout_in | ~master_clear_pin_n;
   logic [15:0] quiet;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn || any_src) quiet <= 16'h0000;
      else if (quiet != 16'hFFFF) quiet <= quiet + 16'h0001;
   end
   sequence s_status_rd;
      psel && penable && pready && !pwrite && paddr == `RSS_ADDR_STATUS;
   endsequence
   sequence s_slow_wake;
      core_halted ##[1:8] !core_halted;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   chk_src_reset: assert property (sync_src |=> master_system_reset)
      else $error("source did not raise system reset");
   chk_release_hold: assert property ($fell(master_system_reset) |-> quiet >= TRST_CYC - 1)
      else $error("system reset released too early");
   chk_release_due: assert property (quiet > TRST_CYC + 8 |-> !master_system_reset)
      else $error("system reset held too long");
   chk_fuse_forces: assert property (fuse_watchdog_enable
      && $past(fuse_watchdog_enable) && $past(rstn) && !master_system_reset
      |-> watchdog_enabled)
      else $error("fuse did not force watchdog on");
   chk_sleep_halts: assert property (sleep_instr && !core_halted
      && !master_system_reset |=> core_halted)
      else $error("power-save did not halt core");
   chk_standby_pair: assert property (regulator_standby == program_mem_off
      && (core_halted || !regulator_standby))
      else $error("standby outside low power or unpaired");
   chk_wake_delay: assert property (core_halted && regulator_standby && wake_req
      && !master_system_reset |=> s_slow_wake)
      else $error("standby wake delay wrong");
   chk_spare_zero: assert property (s_status_rd |-> prdata[31:16] == 16'h0000
      && prdata[13:10] == 4'h0)
      else $error("unimplemented status bits not zero");
endmodule // rss_reset_status_checker
bind rss_reset_status rss_reset_status_checker #(.TRST_CYC(TRST_CYC)) u_chk (.*);
`default_nettype wire

/* File: tb/rss_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rss_src_model (
   input wire logic clk, // system clock
   input wire logic go, // start an event
   input wire logic [3:0] sel, // event index
   input wire logic [3:0] len, // cycles held, 1 for an instruction pulse
   output logic [11:0] ev // event lines, all low when quiet
);
   logic [3:0] left = 4'h0;
   logic [3:0] cur = 4'h0;
   // count the event down; lines drop at once so no stale source lingers
   always @(posedge clk) begin
      if (go) begin
         left <= len;
         cur <= sel;
      end else if (left != 4'h0) left <= left - 4'h1;
   end
   assign ev = (left != 4'h0) ? (12'h001 << cur) : 12'h000;
endmodule // rss_src_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rss_consts.vh"
module testbench;
   logic clk = 1'b0, rstn, go, psel, penable, pwrite, pready, pslverr, e, fuse_watchdog_enable;
   logic master_system_reset, watchdog_enabled, regulator_standby, program_mem_off, core_halted;
   logic [2:0] initial_oscillator_select, osc_current, oscillator_control_reg;
   logic [3:0] sel, len;
   logic [11:0] ev, paddr;
   logic [31:0] pwdata, prdata, d;
   int mismatches = 0, compares = 0;
   int cause[8] = '{6, 4, 9, 15, 14, 14, 7, 1};
   wire soft_reset_req = ev[0], wdt_timeout = ev[1], cfg_mismatch = ev[2], trap_conflict = ev[3];
   wire bad_opcode = ev[4], uninit_wreg_reset = ev[5], master_clear_pin_n = ~ev[6];
   wire brownout_in = ev[7], sleep_instr = ev[8], idle_instr = ev[9];
   wire watchdog_clear_instr = ev[10], wake_req = ev[11];
   rss_reset_status #(.TRST_CYC(4), .TVREG_CYC(3)) dut (.*);
   rss_src_model model (.*);
   // free-running 25 mhz clock
   always #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // bounded wait, sampled mid-cycle where registered outputs are settled
   task automatic wait_on(input logic halt, input logic v);
      int n;
      n = 0;
      while ((halt ? core_halted : master_system_reset) !== v && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n >= 100) begin mismatches++; complete_run; end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
      @(posedge clk);
      penable <= 1'b1;
      // pready, read data and error are all taken at the same rising edge
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      d = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 50) begin mismatches++; complete_run; end
   endtask
   task automatic fire(input logic [3:0] s, input logic [3:0] n);
      @(posedge clk);
      {go, sel, len} <= {1'b1, s, n};
      @(posedge clk);
      go <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_por;
      wait_on(0, 1'b0);
      check("osc", oscillator_control_reg, 3'h5);
      apb(0, `RSS_ADDR_STATUS, 0);
      check("por status", d, 32'h3);
      apb(1, `RSS_ADDR_STATUS, 32'hFFFFFFFF);
      apb(0, `RSS_ADDR_STATUS, 0);
      check("all set", d, 32'hC3FF);
      check("no reset", master_system_reset, 1'b0);
      $display("test por done");
   endtask
   task automatic t_sources;
      apb(1, `RSS_ADDR_CAL, 32'h1234);
      apb(1, `RSS_ADDR_CTRL, 32'hA55A);
      for (int i = 0; i < 8; i++) begin
         apb(1, `RSS_ADDR_STATUS, 0);
         fire(i[3:0], 4'h4);
         wait_on(0, 1'b1);
         wait_on(0, 1'b0);
         apb(0, `RSS_ADDR_STATUS, 0);
         check("cause", d, 32'h1 << cause[i]);
         check("osc", oscillator_control_reg, i == 7 ? 3'h5 : 3'h2);
      end
      apb(0, `RSS_ADDR_CAL, 0);
      check("cal kept", d, 32'h1234);
      apb(0, `RSS_ADDR_CTRL, 0);
      check("scratch kept", d, 32'hA55A);
      $display("test sources done");
   endtask
   task automatic t_power;
      apb(1, `RSS_ADDR_STATUS, 32'h10);
      fire(4'h8, 4'h1);
      wait_on(1, 1'b1);
      check("standby", {regulator_standby, program_mem_off}, 2'b11);
      apb(0, `RSS_ADDR_STATUS, 0);
      check("sleep flags", d, 32'h8);
      fire(4'hB, 4'h1);
      // standby wake: halted through the three delay cycles after the wake edge
      repeat (4) @(negedge clk);
      check("wake delay", core_halted, 1'b1);
      wait_on(1, 1'b0);
      apb(1, `RSS_ADDR_STATUS, 32'h100);
      fire(4'h9, 4'h1);
      wait_on(1, 1'b1);
      check("active", {regulator_standby, program_mem_off}, 2'b00);
      apb(0, `RSS_ADDR_STATUS, 0);
      check("idle flags", d, 32'h104);
      fire(4'hB, 4'h1);
      repeat (2) @(negedge clk);
      check("no wake delay", core_halted, 1'b0);
      wait_on(1, 1'b0);
      apb(1, `RSS_ADDR_STATUS, 32'h10);
      fire(4'hA, 4'h1);
      apb(0, `RSS_ADDR_STATUS, 0);
      check("wdt clear", d, 32'h0);
      $display("test power done");
   endtask
   task automatic t_misc;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         fuse_watchdog_enable <= (i == 0);
         apb(1, `RSS_ADDR_STATUS, i == 2 ? 32'h20 : 32'h0);
         repeat (2) @(negedge clk);
         check("watchdog", watchdog_enabled, i != 1);
      end
      apb(0, 12'h020, 0);
      check("unmapped err", e, 1'b1);
      check("unmapped data", d, 32'h0);
      $display("test misc done");
   endtask
   // second power-on in mid-run with every flag set
   task automatic t_repor;
      apb(1, `RSS_ADDR_STATUS, 32'hFFFFFFFF);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      wait_on(0, 1'b0);
      check("osc repor", oscillator_control_reg, 3'h5);
      apb(0, `RSS_ADDR_STATUS, 0);
      check("repor status", d, 32'h3);
      apb(0, `RSS_ADDR_CAL, 0);
      check("cal cleared", d, 32'h0);
      $display("test repor done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {go, psel, penable, pwrite, fuse_watchdog_enable, rstn} = 6'h00;
      {sel, len, paddr, pwdata} = 52'h0;
      {initial_oscillator_select, osc_current} = 6'h2A;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_por;
      t_sources;
      t_power;
      t_misc;
      t_repor;
      complete_run;
   end
endmodule // testbench
`default_nettype wire
